/* rtl/acbi_pkg.sv */
// Shared constants and types for the asynchronous processor bus interface
package acbi_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 23;
   localparam logic [2:0] IRQ_NONE = 3'h0;
   localparam logic [2:0] IRQ_NMI = 3'h7;
   localparam logic [2:0] SPACE_CPU = 3'h7;
   localparam logic [2:0] SPACE_UDATA = 3'h1;
   localparam logic [2:0] SPACE_UPROG = 3'h2;
   localparam logic [2:0] SPACE_SDATA = 3'h5;
   localparam logic [2:0] SPACE_SPROG = 3'h6;
   localparam logic [ADDR_W-1:0] ADDR_ONES = {ADDR_W{1'b1}};
   localparam logic [1:0] MODE_LATCH_CLKS = 2'h2;
   localparam int RESET_OUT_NS = 5000;
   localparam int CLK_NS = 50;
   localparam int RESET_OUT_CYC = RESET_OUT_NS / CLK_NS;
   localparam logic [7:0] RESET_OUT_LEN = 8'(RESET_OUT_CYC);
   localparam int BUS_PARK_CYC = 1;
   typedef enum logic [2:0] {
      ACBI_IDLE, ACBI_ADDR, ACBI_STROBE, ACBI_END, ACBI_HELD, ACBI_GRANTED
   } acbi_state_t;
   typedef enum logic [1:0] {ACBI_KIND_DATA, ACBI_KIND_IACK} acbi_kind_t;
   function automatic logic [1:0] acbi_lanes(input logic wide, input logic word,
                                             input logic a0);
      if (!wide) acbi_lanes = 2'h1;
      else if (word) acbi_lanes = 2'h3;
      else acbi_lanes = a0 ? 2'h1 : 2'h2;
   endfunction : acbi_lanes
endpackage : acbi_pkg

/* rtl/acbi_sync2.sv */
// Two stage synchroniser for asynchronous bus inputs
`timescale 1ns/100ps
module acbi_sync2 #(parameter int W = 1, parameter logic [W-1:0] INIT = '0) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : acbi_sync2

/* rtl/acbi_core.sv */
// Processor side bus interface: strobes, arbitration, interrupts, halt, reset
`timescale 1ns/100ps
module acbi_core
   import acbi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic two_wire_irq,
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic req_word,
   input wire logic req_iack,
   input wire logic [ADDR_W:0] req_addr,
   input wire logic [2:0] req_space,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic reset_instr,
   input wire logic cpu_stopped,
   output logic req_done,
   output logic req_fault,
   output logic [DATA_W-1:0] rd_data,
   output logic bus_wide,
   output logic [2:0] irq_level,
   output logic sys_init,
   output logic [ADDR_W:0] addr_out,
   output logic addr_oe,
   output logic addr_valid_strobe,
   output logic rw_dir,
   output logic upper_byte_strobe,
   output logic lower_byte_strobe,
   output logic ctrl_oe,
   output logic [2:0] space_code,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic xfer_ack_n,
   input wire logic bus_req_in_n,
   output logic bus_grant_out_n,
   input wire logic grant_ack_in_n,
   input wire logic irq_level_b0_n,
   input wire logic irq_level_b1_n,
   input wire logic irq_level_b2_n,
   input wire logic bus_fault_in_n,
   input wire logic reset_pin_in_n,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   input wire logic halt_pin_in_n,
   output logic halt_pin_out,
   output logic halt_pin_oe,
   input wire logic width_sel
);
   logic rst_meta, rst_s_n;
   acbi_state_t state;
   logic [1:0] mode_cnt;
   logic [7:0] rst_cnt;
   logic ack_s, fault_s, req_s, gack_s, halt_s, rstin_s;
   logic [2:0] ipl_s;
   logic [DATA_W-1:0] din_s;
   logic read_q, word_q;
   logic [1:0] lanes;
   logic [DATA_W-1:0] next_wdata;

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_s_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_s_n <= rst_meta;
      end
   end

   acbi_sync2 #(.W(7), .INIT(7'h7f)) u_sync_ctl (
      .clk_sys(clk_sys),
      .rst_n(rst_s_n),
      .d({xfer_ack_n, bus_fault_in_n, bus_req_in_n, grant_ack_in_n, halt_pin_in_n,
          reset_pin_in_n, irq_level_b1_n}),
      .q({ack_s, fault_s, req_s, gack_s, halt_s, rstin_s, ipl_s[1]})
   );
   acbi_sync2 #(.W(2), .INIT(2'h3)) u_sync_ipl (
      .clk_sys(clk_sys),
      .rst_n(rst_s_n),
      .d({irq_level_b2_n, irq_level_b0_n}),
      .q({ipl_s[2], ipl_s[0]})
   );
   acbi_sync2 #(.W(DATA_W), .INIT('0)) u_sync_data (
      .clk_sys(clk_sys),
      .rst_n(rst_s_n),
      .d(data_in),
      .q(din_s)
   );

   // Width pin caught after release; no change later
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         mode_cnt <= '0;
         bus_wide <= 1'b1;
      end else if (mode_cnt != MODE_LATCH_CLKS) begin
         mode_cnt <= mode_cnt + 2'h1;
         if (mode_cnt == MODE_LATCH_CLKS - 2'h1) bus_wide <= width_sel;
      end
   end

   // Active low level pins inverted; two wire variant (two_wire_irq) shares one pin
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) irq_level <= IRQ_NONE;
      else if (two_wire_irq) irq_level <= {~ipl_s[0], ~ipl_s[1], ~ipl_s[0]};
      else irq_level <= ~ipl_s;
   end

   // Both pins low together means full system initialisation
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) sys_init <= 1'b0;
      // Own outward pulse must not read back as a system initialisation
      else sys_init <= !rstin_s && !halt_s && !reset_pin_oe;
   end

   // Outward reset pulse leaves the bus state machine alone
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         rst_cnt <= '0;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
      end else if (reset_instr && rst_cnt == '0) begin
         rst_cnt <= RESET_OUT_LEN;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b1;
      end else if (rst_cnt != '0) begin
         rst_cnt <= rst_cnt - 8'h1;
         reset_pin_oe <= (rst_cnt != 8'h1);
      end
   end

   // Open drain halt pulled low while the core is stopped
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         halt_pin_out <= 1'b0;
         halt_pin_oe <= 1'b0;
      end else begin
         halt_pin_out <= 1'b0;
         halt_pin_oe <= cpu_stopped;
      end
   end

   assign lanes = acbi_lanes(bus_wide, word_q, addr_out[0]);
   // Narrow and odd byte writes copy the low byte upward, even ones the high byte downward; bus logic must not rely on it
   always_comb begin
      next_wdata = req_wdata;
      if (!bus_wide) next_wdata = {req_wdata[7:0], req_wdata[7:0]};
      else if (!req_word) next_wdata = req_addr[0] ? {req_wdata[7:0], req_wdata[7:0]}
                                       : {req_wdata[15:8], req_wdata[15:8]};
   end

   // Bus cycle sequencer
   always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state <= ACBI_IDLE;
         addr_out <= '0;
         addr_oe <= 1'b0;
         addr_valid_strobe <= 1'b1;
         rw_dir <= 1'b1;
         upper_byte_strobe <= 1'b1;
         lower_byte_strobe <= 1'b1;
         ctrl_oe <= 1'b0;
         space_code <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
         bus_grant_out_n <= 1'b1;
         read_q <= 1'b1;
         word_q <= 1'b0;
         req_done <= 1'b0;
         req_fault <= 1'b0;
         rd_data <= '0;
      end else begin
         req_done <= 1'b0;
         req_fault <= 1'b0;
         unique case (state)
            ACBI_IDLE: begin
               if (!req_s || !gack_s) begin
                  bus_grant_out_n <= 1'b0;
                  state <= ACBI_GRANTED;
                  ctrl_oe <= 1'b0;
                  addr_oe <= 1'b0;
               end else if (!halt_s) begin
                  ctrl_oe <= 1'b1;
                  addr_oe <= 1'b0;
                  data_oe <= 1'b0;
               end else if (req_valid) begin
                  ctrl_oe <= 1'b1;
                  addr_oe <= 1'b1;
                  read_q <= req_read || req_iack;
                  word_q <= req_word;
                  rw_dir <= req_read || req_iack;
                  if (req_iack) begin
                     addr_out <= {ADDR_ONES[ADDR_W-1:3], irq_level, 1'b1};
                     space_code <= SPACE_CPU;
                  end else begin
                     addr_out <= req_addr;
                     space_code <= req_space;
                  end
                  data_out <= next_wdata;
                  state <= ACBI_ADDR;
               end
            end
            ACBI_ADDR: begin
               addr_valid_strobe <= 1'b0;
               data_oe <= !read_q;
               state <= ACBI_STROBE;
            end
            ACBI_STROBE: begin
               upper_byte_strobe <= ~lanes[1];
               lower_byte_strobe <= ~lanes[0];
               if (!fault_s && !halt_s) begin
                  state <= ACBI_HELD;
               end else if (!fault_s) begin
                  req_fault <= 1'b1;
                  state <= ACBI_END;
               end else if (!ack_s && (!upper_byte_strobe || !lower_byte_strobe)) begin
                  if (read_q) rd_data <= bus_wide ? din_s : {8'h00, din_s[7:0]};
                  req_done <= 1'b1;
                  state <= ACBI_END;
               end
            end
            ACBI_HELD: begin
               addr_valid_strobe <= 1'b1;
               upper_byte_strobe <= 1'b1;
               lower_byte_strobe <= 1'b1;
               data_oe <= 1'b0;
               if (halt_s && fault_s) state <= ACBI_ADDR;
            end
            ACBI_END: begin
               addr_valid_strobe <= 1'b1;
               upper_byte_strobe <= 1'b1;
               lower_byte_strobe <= 1'b1;
               data_oe <= 1'b0;
               addr_oe <= 1'b0;
               if (ack_s && fault_s) state <= ACBI_IDLE;
            end
            ACBI_GRANTED: begin
               // Released master keeps off the bus until all arbitration lines idle
               if (req_s && gack_s) begin
                  bus_grant_out_n <= 1'b1;
                  ctrl_oe <= 1'b1;
                  state <= ACBI_IDLE;
               end else if (!gack_s) begin
                  bus_grant_out_n <= 1'b1;
               end
            end
            default: state <= ACBI_IDLE;
         endcase
      end
   end

   a_strobe_addr: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      !addr_valid_strobe |-> addr_oe) else $error("strobe without address");
   a_narrow_upper: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      !bus_wide |-> upper_byte_strobe) else $error("upper strobe in narrow mode");
   a_write_drive: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      (!data_oe && !rw_dir && !addr_valid_strobe && state == ACBI_STROBE) |-> 1'b0)
      else $error("write without data drive");
   a_read_float: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      rw_dir |-> !data_oe) else $error("data driven in read");
   a_ack_done: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      req_done |-> $past(state) == ACBI_STROBE && !$past(ack_s))
      else $error("done without ack");
   a_grant_idle: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      $fell(bus_grant_out_n) |=> addr_valid_strobe && !addr_oe)
      else $error("grant with bus active");
   a_halt_out: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      cpu_stopped |=> halt_pin_oe && !halt_pin_out) else $error("halt not driven");
   a_reset_pulse: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      $rose(reset_pin_oe) |=> reset_pin_oe [*8]) else $error("reset pulse short");
   a_iack_space: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      $rose(addr_oe) && addr_out[ADDR_W:4] == '1 && space_code == SPACE_CPU |-> addr_out[0])
      else $error("acknowledge address");
   a_nmi_seen: assert property (@(posedge clk_sys) disable iff (!rst_s_n)
      (!two_wire_irq && ipl_s == 3'h0) |=> irq_level == IRQ_NMI)
      else $error("level seven lost");
endmodule : acbi_core

/* dv/acbi_mem.sv */
// Far side model: memory or peripheral that acknowledges or faults a cycle
`timescale 1ns/100ps
module acbi_mem
   import acbi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic ub_n,
   input wire logic lb_n,
   input wire logic rw,
   input wire logic fault,
   input wire logic [DATA_W-1:0] pat,
   output logic xfer_ack_n,
   output logic bus_fault_in_n,
   output logic [DATA_W-1:0] data_in
);
   logic [2:0] cnt;
   initial begin
      cnt = 3'h0;
      xfer_ack_n = 1'b1;
      bus_fault_in_n = 1'b1;
      data_in = 16'h0000;
   end
   // Answers a few cycles after a lane strobe, never at once
   always @(posedge clk_sys) begin
      if (!ub_n || !lb_n) begin
         if (cnt != 3'h3) cnt <= cnt + 3'h1;
         else if (fault) bus_fault_in_n <= 1'b0;
         else begin
            xfer_ack_n <= 1'b0;
            if (rw) data_in <= pat; // Vector on low lane too
         end
      end else begin
         cnt <= 3'h0;
         xfer_ack_n <= 1'b1;
         bus_fault_in_n <= 1'b1;
         data_in <= ~data_in; // Released bus never keeps its last value
      end
   end
endmodule : acbi_mem

/* dv/tb.sv */
// Self-checking bench for the processor bus interface core
`timescale 1ns/100ps
module tb
   import acbi_pkg::*;
;
   localparam logic [DATA_W-1:0] PAT = 16'hc3a5;
   logic clk_sys = 1'b0, rst_n = 1'b0, two_wire_irq = 1'b0, req_valid = 1'b0, req_read = 1'b0;
   logic req_word = 1'b0, req_iack = 1'b0, reset_instr = 1'b0, cpu_stopped = 1'b0, flt = 1'b0;
   logic [ADDR_W:0] req_addr = '0;
   logic [2:0] req_space = 3'h0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic bus_req_in_n = 1'b1, grant_ack_in_n = 1'b1, ext_rst_n = 1'b1, ext_halt_n = 1'b1;
   logic irq_level_b0_n = 1'b1, irq_level_b1_n = 1'b1, irq_level_b2_n = 1'b1, width_sel = 1'b1;
   logic req_done, req_fault, bus_wide, sys_init, addr_oe, addr_valid_strobe, rw_dir, ctrl_oe;
   logic upper_byte_strobe, lower_byte_strobe, data_oe, bus_grant_out_n, xfer_ack_n;
   logic reset_pin_out, reset_pin_oe, halt_pin_out, halt_pin_oe, bus_fault_in_n;
   logic [DATA_W-1:0] rd_data, data_out, data_in, sdo;
   logic [2:0] irq_level, space_code, ssp;
   logic [ADDR_W:0] addr_out, sad;
   logic [1:0] sl;
   logic srw, soe, sas, gd, gf;
   wire reset_pin_in_n = ext_rst_n & ~reset_pin_oe;
   wire halt_pin_in_n = ext_halt_n & ~halt_pin_oe;
   int fail_count = 0, checked = 0;
   always #25 clk_sys = ~clk_sys;
   acbi_core acbi_core_inst (.clk_sys, .rst_n, .two_wire_irq, .req_valid, .req_read, .req_word,
      .req_iack, .req_addr, .req_space, .req_wdata, .reset_instr, .cpu_stopped, .req_done,
      .req_fault, .rd_data, .bus_wide, .irq_level, .sys_init, .addr_out, .addr_oe,
      .addr_valid_strobe, .rw_dir, .upper_byte_strobe, .lower_byte_strobe, .ctrl_oe, .space_code,
      .data_in, .data_out, .data_oe, .xfer_ack_n, .bus_req_in_n, .bus_grant_out_n,
      .grant_ack_in_n, .irq_level_b0_n, .irq_level_b1_n, .irq_level_b2_n, .bus_fault_in_n,
      .reset_pin_in_n, .reset_pin_out, .reset_pin_oe, .halt_pin_in_n, .halt_pin_out,
      .halt_pin_oe, .width_sel);
   acbi_mem acbi_mem_inst (.clk_sys, .ub_n(upper_byte_strobe), .lb_n(lower_byte_strobe),
      .rw(rw_dir), .fault(flt), .pat(PAT), .xfer_ack_n, .bus_fault_in_n, .data_in);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic run(input logic rd, wd, ia, input logic [ADDR_W:0] ad,
      input logic [2:0] sp, input logic [DATA_W-1:0] wv);
      int n;
      @(posedge clk_sys);
      req_read <= rd;
      req_word <= wd;
      req_iack <= ia;
      req_addr <= ad;
      req_space <= sp;
      req_wdata <= wv;
      req_valid <= 1'b1;
      gd = 1'b0;
      gf = 1'b0;
      for (n = 0; n < 200 && !gd && !gf; n++) begin
         @(negedge clk_sys);
         if (upper_byte_strobe === 1'b0 || lower_byte_strobe === 1'b0) begin
            sl = {upper_byte_strobe, lower_byte_strobe};
            srw = rw_dir;
            sdo = data_out;
            soe = data_oe;
            ssp = space_code;
            sad = addr_out;
            sas = addr_valid_strobe;
         end
         gd = req_done === 1'b1;
         gf = req_fault === 1'b1;
      end
      @(posedge clk_sys);
      req_valid <= 1'b0;
      repeat (8) @(posedge clk_sys); // Ack must be gone before the next request
   endtask : run
   task automatic t_word();
      run(1'b1, 1'b1, 1'b0, 24'h001000, SPACE_SDATA, 16'h0000);
      chk(gd, 1'b1);
      chk(rd_data, PAT);
      chk(sl, 2'h0);
      chk(srw, 1'b1);
      chk({sas, sad}, {1'b0, 24'h001000});
      chk(ssp, SPACE_SDATA);
   endtask : t_word
   task automatic t_lanes();
      for (int i = 0; i < 4; i++) begin
         run(i[1], 1'b0, 1'b0, {23'h000800, i[0]}, SPACE_UDATA, i[0] ? 16'h005a : 16'h5a00);
         chk(sl, i[0] ? 2'h2 : 2'h1);
         chk({srw, soe}, {i[1], ~i[1]});
         if (!i[1]) chk(sdo, 16'h5a5a);
         if (i[1]) chk(rd_data, PAT);
      end
   endtask : t_lanes
   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         {irq_level_b2_n, irq_level_b1_n, irq_level_b0_n} <= ~i[2:0];
         repeat (5) @(posedge clk_sys);
         chk(irq_level, i[2:0]);
      end
      two_wire_irq <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         {irq_level_b2_n, irq_level_b1_n, irq_level_b0_n} <= {i[0], ~i[1], ~i[0]};
         repeat (5) @(posedge clk_sys);
         chk(irq_level, {i[0], i[1], i[0]});
      end
      two_wire_irq <= 1'b0;
      {irq_level_b2_n, irq_level_b1_n, irq_level_b0_n} <= 3'h2; // Held through acknowledge
      repeat (5) @(posedge clk_sys);
      run(1'b1, 1'b0, 1'b1, 24'hfffffb, SPACE_CPU, 16'h0000);
      chk(sad, 24'hfffffb);
      chk(ssp, SPACE_CPU);
      chk(rd_data[7:0], PAT[7:0]);
      {irq_level_b2_n, irq_level_b1_n, irq_level_b0_n} <= 3'h7;
   endtask : t_irq
   task automatic t_sys();
      int n = 0;
      flt <= 1'b1;
      run(1'b1, 1'b1, 1'b0, 24'h000200, SPACE_UPROG, 16'h0000);
      chk({gf, gd}, 2'h2);
      flt <= 1'b0;
      reset_instr <= 1'b1;
      @(posedge clk_sys);
      reset_instr <= 1'b0;
      repeat (400) @(posedge clk_sys) n += int'(reset_pin_oe === 1'b1);
      chk(n, RESET_OUT_CYC);
      cpu_stopped <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(halt_pin_oe, 1'b1);
      cpu_stopped <= 1'b0;
      bus_req_in_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({bus_grant_out_n, addr_valid_strobe, ctrl_oe}, 3'h2);
      grant_ack_in_n <= 1'b0;
      // Request kept low while the claim stands
      repeat (8) @(posedge clk_sys);
      chk({bus_grant_out_n, ctrl_oe}, 2'h2);
      grant_ack_in_n <= 1'b1;
      bus_req_in_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({bus_grant_out_n, ctrl_oe}, 2'h3);
   endtask : t_sys
   task automatic t_retry();
      int n;
      gd = 1'b0;
      gf = 1'b0;
      flt <= 1'b1;
      @(posedge clk_sys);
      req_read <= 1'b1;
      req_word <= 1'b1;
      req_iack <= 1'b0;
      req_addr <= 24'h000300;
      req_space <= SPACE_SDATA;
      req_valid <= 1'b1;
      for (n = 0; n < 50 && lower_byte_strobe !== 1'b0; n++) @(posedge clk_sys);
      // Halt lands before the fault is seen, so the cycle must be held
      ext_halt_n <= 1'b0;
      repeat (20) @(posedge clk_sys) gf |= req_fault === 1'b1;
      chk({gf, addr_valid_strobe, upper_byte_strobe, lower_byte_strobe}, 4'h7);
      flt <= 1'b0;
      ext_halt_n <= 1'b1;
      for (n = 0; n < 50 && !gd; n++) @(negedge clk_sys) gd = req_done === 1'b1;
      chk({gd, rd_data}, {1'b1, PAT});
      @(posedge clk_sys);
      req_valid <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : t_retry
   task automatic t_narrow();
      ext_rst_n <= 1'b0;
      ext_halt_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(sys_init, 1'b1);
      chk({ctrl_oe, addr_oe, data_oe, addr_valid_strobe}, 4'h9);
      ext_rst_n <= 1'b1;
      ext_halt_n <= 1'b1;
      width_sel <= 1'b0; // Stable long before and after release
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(bus_wide, 1'b0);
      run(1'b0, 1'b0, 1'b0, 24'h000040, SPACE_UDATA, 16'h0033);
      chk({gd, sl}, 3'h6);
      chk({srw, sdo[7:0]}, 9'h033);
      run(1'b1, 1'b0, 1'b0, 24'h000041, SPACE_UDATA, 16'h0000);
      chk({gd, sl, rd_data}, {1'b1, 2'h2, 8'h00, PAT[7:0]});
   endtask : t_narrow
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(negedge clk_sys);
      chk(bus_wide, 1'b1);
      t_word();
      t_lanes();
      t_irq();
      t_sys();
      t_retry();
      t_narrow();
      give_verdict();
   end
endmodule : tb
